// ### hw/pcs_pkg.sv
package pcs_pkg;
	// clock and timing
	localparam int CLK_MHZ = 50;
	localparam int TON_LSB_US = 500;
	localparam int HALF_MS_CYCLES = TON_LSB_US * CLK_MHZ;
	// command codes
	localparam logic [7:0] CMD_OPERATION = 8'h01;
	localparam logic [7:0] CMD_CLEAR_FAULTS = 8'h03;
	localparam logic [7:0] CMD_STORE_ALL = 8'h11;
	localparam logic [7:0] CMD_VOUT_MODE = 8'h20;
	localparam logic [7:0] CMD_VOUT_SET = 8'h21;
	localparam logic [7:0] CMD_MARGIN_HI = 8'h25;
	localparam logic [7:0] CMD_MARGIN_LO = 8'h26;
	localparam logic [7:0] CMD_VIN_ON = 8'h35;
	localparam logic [7:0] CMD_VIN_OFF = 8'h36;
	localparam logic [7:0] CMD_TON_DELAY = 8'h60;
	localparam logic [7:0] CMD_TON_RISE = 8'h61;
	localparam logic [7:0] CMD_STATUS_WORD = 8'h79;
	localparam logic [7:0] CMD_OUTPUT_VOLTAGE_STATUS = 8'h7A;
	localparam logic [7:0] CMD_OUTPUT_CURRENT_STATUS = 8'h7B;
	localparam logic [7:0] CMD_READ_VIN = 8'h88;
	localparam logic [7:0] CMD_READ_VOUT = 8'h8B;
	localparam logic [7:0] CMD_READ_IOUT = 8'h8C;
	localparam logic [7:0] CMD_READ_TEMP = 8'h8D;
	localparam logic [7:0] CMD_VOUT_TRIM = 8'hD0;
	localparam logic [7:0] CMD_VIN_TRIM = 8'hD1;
	localparam logic [7:0] CMD_VIN_SCALE = 8'hD2;
	localparam logic [7:0] CMD_CUR_TRIM = 8'hD3;
	localparam logic [7:0] CMD_CUR_SCALE = 8'hD4;
	// linear format exponents
	localparam logic [4:0] EXP_M1 = 5'h1F;
	localparam logic [4:0] EXP_M2 = 5'h1E;
	localparam logic [4:0] EXP_M3 = 5'h1D;
	localparam logic [4:0] EXP_M4 = 5'h1C;
	localparam logic [7:0] VOUT_MODE_VAL = 8'h14;
	localparam int GAIN_SHIFT = 13;
	localparam logic [9:0] MANT_MAX = 10'h3FF;
	// setting limits
	localparam int VIN_LSB_MV = 125;
	localparam logic [9:0] VIN_MIN = 10'(32000 / VIN_LSB_MV);
	localparam logic [9:0] VIN_MAX = 10'(46000 / VIN_LSB_MV);
	localparam logic [9:0] VIN_HYST = 10'(2000 / VIN_LSB_MV);
	localparam int TON_LSB_UUS = 500;
	localparam logic [9:0] TON_DELAY_MIN = 10'(10000 / TON_LSB_UUS);
	localparam logic [9:0] TON_RISE_MIN = 10'(15000 / TON_LSB_UUS);
	localparam logic [9:0] TON_MAX = 10'(500000 / TON_LSB_UUS);
	localparam logic [15:0] VOUT_MIN = 16'((8100 * 4096 + 999) / 1000);
	localparam logic [15:0] VOUT_MAX = 16'((13200 * 4096) / 1000);
	localparam logic [15:0] MARGIN_MIN = 16'((5000 * 4096 + 999) / 1000);
	localparam logic [15:0] VOUT_DEFAULT = 16'hC000;
	localparam int IOUT_LSB_UA = 62500;
	localparam logic [9:0] IOUT_BLANK =
		10'((1650000 + IOUT_LSB_UA - 1) / IOUT_LSB_UA);
	// operation byte
	localparam int OP_EN_BIT = 7;
	localparam logic [7:0] OP_WR_MASK = 8'hB0;
	localparam logic [7:0] OP_FIXED = 8'h08;
	localparam logic [7:0] OP_DEFAULT = 8'h88;
	localparam logic [1:0] MRG_OFF = 2'h0;
	localparam logic [1:0] MRG_LOW = 2'h1;
	localparam logic [1:0] MRG_HIGH = 2'h2;
	// status bit positions
	localparam int SW_VOUT = 15;
	localparam int SW_IOUT = 14;
	localparam int SW_INPUT = 13;
	localparam int SW_PGN = 11;
	localparam int SW_OFF = 6;
	localparam int SW_OV = 5;
	localparam int SW_OC = 4;
	localparam int SW_UV = 3;
	localparam int SW_TEMP = 2;
	localparam int SW_CML = 1;
	localparam int SV_OV = 7;
	localparam int SI_OC = 7;
	localparam int SI_WARN = 5;

	typedef struct packed {
		logic wr;
		logic [7:0] code;
		logic [15:0] data;
	} pcs_req_t;

	typedef struct packed {
		logic ok;
		logic [15:0] data;
	} pcs_rsp_t;

	typedef struct packed {
		logic [15:0] vout_trim;
		logic [15:0] vin_trim;
		logic [15:0] vin_scale;
		logic [15:0] cur_trim;
		logic [15:0] cur_scale;
	} pcs_cal_t;

	typedef struct packed {
		logic [15:0] vin_on;
		logic [15:0] vin_off;
		logic [15:0] ton_delay;
		logic [15:0] ton_rise;
		logic [15:0] vout_set;
		logic [15:0] margin_hi;
		logic [15:0] margin_lo;
	} pcs_image_t;

	typedef enum logic [1:0] {
		SEQ_OFF = 2'b00,
		SEQ_DELAY = 2'b01,
		SEQ_RISE = 2'b10,
		SEQ_ON = 2'b11
	} pcs_seq_t;
endpackage : pcs_pkg

// ### hw/pcs_top.sv
// Summary of operation
// - Input on/off thresholds accept 32.000 V to 46.000 V in 0.125 V steps.
// - Turn-on threshold stays at least 2.000 V above turn-off threshold.
// - Threshold words: exponent -3 in high bits, 11-bit mantissa, top zero.
// - Store-all copies thresholds, timings, set point and margins to memory.
// - Turn-on delay 10 to 500 ms, 0.5 ms steps, waited before ramp.
// - Rise time 15 to 500 ms in 0.5 ms steps; host picks it safely.
// - Delay and rise words: exponent -1, 11-bit mantissa, top bit zero.
// - Set point is 16-bit unsigned, exponent -12, reported by mode query.
// - Set point limited to 8.10 V through 13.20 V, 0.244 mV per count.
// - Margin high and low words are unsigned with exponent -12.
// - Operation bits 5:4 select no margin, low or high; faults still act.
// - Output voltage readback is 16-bit unsigned at exponent -12.
// - Signed output voltage offset added to raw reading; offset readable.
// - Input voltage readback: exponent -3, 11-bit mantissa, top bit zero.
// - Input reading corrected by readable gain/8192 and offset.
// - Current readback: exponent -4, reads zero below 1.65 A.
// - Current corrected by gain/8192 plus offset, and temperature corrected.
// - Current reads zero while the converter sinks current.
// - Temperature readback: exponent -2, signed 11-bit mantissa.
// - Status word bits 15,14,13,11,6,5,4,3,2,1 carry the summary flags.
// - Output voltage status bit 7 overvoltage; current bits 7 fault, 5 warn.
// - Unsupported status bits read zero; latched fault bits default to zero, bit 6 reads one while output is off.
// - Operation bit 7 enables output when one and the on pin is high, disables when zero.
// - Clear-faults clears latched flags and releases the alert output.
`timescale 1ns/1ps
module pcs_top #(
	parameter int HALF_MS = pcs_pkg::HALF_MS_CYCLES,
	parameter logic [15:0] VIN_ON_DEF = 16'hE910,
	parameter logic [15:0] VIN_OFF_DEF = 16'hE900,
	parameter logic [15:0] TON_DELAY_DEF = 16'hF814,
	parameter logic [15:0] TON_RISE_DEF = 16'hF81E,
	parameter logic [15:0] MARGIN_HI_DEF = 16'hC99A,
	parameter logic [15:0] MARGIN_LO_DEF = 16'hB666
) (
	input wire logic sys_clk_i,
	input wire logic rst_i,
	input wire logic link_clk_i,
	input wire logic lk_req_valid_i,
	input wire pcs_pkg::pcs_req_t lk_req_i,
	output pcs_pkg::pcs_rsp_t lk_rsp_o,
	output logic lk_req_ready_o,
	output logic lk_rsp_valid_o,
	input wire logic on_pin_i,
	input wire logic pgood_i,
	input wire logic vout_ov_evt_i,
	input wire logic iout_oc_evt_i,
	input wire logic iout_warn_evt_i,
	input wire logic vin_uv_evt_i,
	input wire logic vin_ov_evt_i,
	input wire logic temp_evt_i,
	input wire logic nvm_fail_i,
	input wire pcs_pkg::pcs_cal_t cal_i,
	input wire logic [15:0] vout_adc_i,
	input wire logic [9:0] vin_adc_i,
	input wire logic [10:0] iout_adc_i,
	input wire logic [10:0] iout_temp_adj_i,
	input wire logic iout_sinking_i,
	input wire logic [10:0] temp_adc_i,
	output logic [15:0] vout_target_o,
	output logic out_enable_o,
	output logic ramp_active_o,
	output logic alert_o,
	output logic nvm_store_o,
	output pcs_pkg::pcs_image_t nvm_image_o
);
	import pcs_pkg::*;

	localparam int TW = $clog2(HALF_MS + 1);
	localparam logic [TW-1:0] TICK_LAST = TW'(HALF_MS - 1);

	// link domain: reset and acknowledge synchronisers
	logic lk_rst_s1, lk_rst;
	logic ack_s1, ack_s2, ack_s3, req_tgl, ack_tgl;
	logic ack_edge;
	pcs_req_t req_hold;
	pcs_rsp_t rsp_hold;

	always_ff @(posedge link_clk_i) begin
		lk_rst_s1 <= rst_i;
		lk_rst <= lk_rst_s1;
		ack_s1 <= ack_tgl;
		ack_s2 <= ack_s1;
		ack_s3 <= ack_s2;
	end
	assign ack_edge = ack_s2 ^ ack_s3;

	// request is held stable from accept until the answer comes back
	always_ff @(posedge link_clk_i) begin
		if (lk_rst) begin
			lk_req_ready_o <= 1'b1;
			req_tgl <= 1'b0;
			req_hold <= '0;
		end else if (lk_req_valid_i && lk_req_ready_o) begin
			req_hold <= lk_req_i;
			req_tgl <= ~req_tgl;
			lk_req_ready_o <= 1'b0;
		end else if (ack_edge) begin
			lk_req_ready_o <= 1'b1;
		end
	end

	always_ff @(posedge link_clk_i) begin
		if (lk_rst) begin
			lk_rsp_valid_o <= 1'b0;
			lk_rsp_o <= '0;
		end else begin
			lk_rsp_valid_o <= ack_edge;
			if (ack_edge) begin
				lk_rsp_o <= rsp_hold;
			end
		end
	end

	// system domain: request toggle and pin synchronisers
	logic req_s1, req_s2, req_s3, exec;
	logic [7:0] pin_s1, pin_s2;

	always_ff @(posedge sys_clk_i) begin
		req_s1 <= req_tgl;
		req_s2 <= req_s1;
		req_s3 <= req_s2;
		pin_s1 <= {on_pin_i, pgood_i, vout_ov_evt_i, iout_oc_evt_i,
			iout_warn_evt_i, vin_uv_evt_i, vin_ov_evt_i, temp_evt_i};
		pin_s2 <= pin_s1;
	end
	assign exec = req_s2 ^ req_s3;

	logic on_pin, pgood, ev_ov, ev_oc, ev_warn, ev_uv, ev_vinov, ev_temp;
	assign {on_pin, pgood, ev_ov, ev_oc, ev_warn, ev_uv, ev_vinov,
		ev_temp} = pin_s2;

	// settings
	logic [7:0] operation;
	pcs_image_t cfg;
	logic [1:0] margin_sel;
	assign margin_sel = operation[5:4];

	// latched status flags and live status
	logic f_ov, f_oc, f_warn, f_uv, f_vinov, f_temp, f_cmd, f_data, f_nvm;
	logic [15:0] status_word;
	logic [7:0] vout_status, cur_status;
	pcs_seq_t seq;

	// telemetry registers
	logic [15:0] rd_vout, rd_vin, rd_cur, rd_temp;

	// decode of the pending request
	logic rd_allowed, wr_allowed, data_ok;
	logic [15:0] rd_data;
	logic [15:0] wd;
	logic [9:0] wm;
	logic [4:0] we;
	assign wd = req_hold.data;
	assign wm = wd[9:0];
	assign we = wd[15:11];

	always_comb begin
		rd_allowed = 1'b0;
		wr_allowed = 1'b0;
		data_ok = 1'b0;
		rd_data = '0;
		unique case (req_hold.code)
			CMD_OPERATION: begin
				rd_allowed = 1'b1;
				wr_allowed = 1'b1;
				rd_data = {8'h00, operation};
				data_ok = (wd[5:4] != 2'b11);
			end
			CMD_CLEAR_FAULTS, CMD_STORE_ALL: begin
				wr_allowed = 1'b1;
				data_ok = 1'b1;
			end
			CMD_VOUT_MODE: begin
				rd_allowed = 1'b1;
				rd_data = {8'h00, VOUT_MODE_VAL};
			end
			CMD_VOUT_SET: begin
				rd_allowed = 1'b1;
				wr_allowed = 1'b1;
				rd_data = cfg.vout_set;
				data_ok = (wd >= VOUT_MIN) && (wd <= VOUT_MAX);
			end
			CMD_MARGIN_HI: begin
				rd_allowed = 1'b1;
				wr_allowed = 1'b1;
				rd_data = cfg.margin_hi;
				data_ok = (wd >= MARGIN_MIN) && (wd <= VOUT_MAX)
					&& (wd > cfg.margin_lo);
			end
			CMD_MARGIN_LO: begin
				rd_allowed = 1'b1;
				wr_allowed = 1'b1;
				rd_data = cfg.margin_lo;
				data_ok = (wd >= MARGIN_MIN) && (wd <= VOUT_MAX)
					&& (wd < cfg.margin_hi);
			end
			CMD_VIN_ON: begin
				rd_allowed = 1'b1;
				wr_allowed = 1'b1;
				rd_data = cfg.vin_on;
				data_ok = (we == EXP_M3) && !wd[10] && (wm >= VIN_MIN)
					&& (wm <= VIN_MAX) && (wm >= cfg.vin_off[9:0] + VIN_HYST);
			end
			CMD_VIN_OFF: begin
				rd_allowed = 1'b1;
				wr_allowed = 1'b1;
				rd_data = cfg.vin_off;
				data_ok = (we == EXP_M3) && !wd[10] && (wm >= VIN_MIN)
					&& (wm <= VIN_MAX) && (wm + VIN_HYST <= cfg.vin_on[9:0]);
			end
			CMD_TON_DELAY: begin
				rd_allowed = 1'b1;
				wr_allowed = 1'b1;
				rd_data = cfg.ton_delay;
				data_ok = (we == EXP_M1) && !wd[10] && (wm >= TON_DELAY_MIN)
					&& (wm <= TON_MAX);
			end
			CMD_TON_RISE: begin
				rd_allowed = 1'b1;
				wr_allowed = 1'b1;
				rd_data = cfg.ton_rise;
				data_ok = (we == EXP_M1) && !wd[10] && (wm >= TON_RISE_MIN)
					&& (wm <= TON_MAX);
			end
			CMD_STATUS_WORD: begin
				rd_allowed = 1'b1;
				rd_data = status_word;
			end
			CMD_OUTPUT_VOLTAGE_STATUS: begin
				rd_allowed = 1'b1;
				rd_data = {8'h00, vout_status};
			end
			CMD_OUTPUT_CURRENT_STATUS: begin
				rd_allowed = 1'b1;
				rd_data = {8'h00, cur_status};
			end
			CMD_READ_VIN: begin
				rd_allowed = 1'b1;
				rd_data = rd_vin;
			end
			CMD_READ_VOUT: begin
				rd_allowed = 1'b1;
				rd_data = rd_vout;
			end
			CMD_READ_IOUT: begin
				rd_allowed = 1'b1;
				rd_data = rd_cur;
			end
			CMD_READ_TEMP: begin
				rd_allowed = 1'b1;
				rd_data = rd_temp;
			end
			CMD_VOUT_TRIM: begin
				rd_allowed = 1'b1;
				rd_data = cal_i.vout_trim;
			end
			CMD_VIN_TRIM: begin
				rd_allowed = 1'b1;
				rd_data = cal_i.vin_trim;
			end
			CMD_VIN_SCALE: begin
				rd_allowed = 1'b1;
				rd_data = cal_i.vin_scale;
			end
			CMD_CUR_TRIM: begin
				rd_allowed = 1'b1;
				rd_data = cal_i.cur_trim;
			end
			CMD_CUR_SCALE: begin
				rd_allowed = 1'b1;
				rd_data = cal_i.cur_scale;
			end
			default: rd_allowed = 1'b0;
		endcase
	end

	logic cmd_bad, data_bad, wr_go, clr_go, store_go;
	assign cmd_bad = exec && (req_hold.wr ? !wr_allowed : !rd_allowed);
	assign data_bad = exec && req_hold.wr && wr_allowed && !data_ok;
	assign wr_go = exec && req_hold.wr && wr_allowed && data_ok;
	assign clr_go = wr_go && (req_hold.code == CMD_CLEAR_FAULTS);
	assign store_go = wr_go && (req_hold.code == CMD_STORE_ALL);

	// answer back to the link domain
	always_ff @(posedge sys_clk_i) begin
		if (rst_i) begin
			rsp_hold <= '0;
			ack_tgl <= 1'b0;
		end else if (exec) begin
			rsp_hold.ok <= !cmd_bad && !data_bad;
			rsp_hold.data <= req_hold.wr ? 16'h0000 : rd_data;
			ack_tgl <= ~ack_tgl;
		end
	end

	// settings writes; rejected values leave the old setting in place
	always_ff @(posedge sys_clk_i) begin
		if (rst_i) begin
			operation <= OP_DEFAULT;
			cfg.vin_on <= VIN_ON_DEF;
			cfg.vin_off <= VIN_OFF_DEF;
			cfg.ton_delay <= TON_DELAY_DEF;
			cfg.ton_rise <= TON_RISE_DEF;
			cfg.vout_set <= VOUT_DEFAULT;
			cfg.margin_hi <= MARGIN_HI_DEF;
			cfg.margin_lo <= MARGIN_LO_DEF;
		end else if (wr_go) begin
			unique case (req_hold.code)
				CMD_OPERATION: operation <= (wd[7:0] & OP_WR_MASK) | OP_FIXED;
				CMD_VOUT_SET: cfg.vout_set <= wd;
				CMD_MARGIN_HI: cfg.margin_hi <= wd;
				CMD_MARGIN_LO: cfg.margin_lo <= wd;
				CMD_VIN_ON: cfg.vin_on <= wd;
				CMD_VIN_OFF: cfg.vin_off <= wd;
				CMD_TON_DELAY: cfg.ton_delay <= wd;
				CMD_TON_RISE: cfg.ton_rise <= wd;
				default: operation <= operation;
			endcase
		end
	end

	always_ff @(posedge sys_clk_i) begin
		if (rst_i) begin
			nvm_store_o <= 1'b0;
			nvm_image_o <= '0;
		end else begin
			nvm_store_o <= store_go;
			if (store_go) begin
				nvm_image_o <= cfg;
			end
		end
	end

	// latched flags, a new event beats a clear in the same cycle
	always_ff @(posedge sys_clk_i) begin
		if (rst_i) begin
			{f_ov, f_oc, f_warn, f_uv, f_vinov, f_temp} <= '0;
			{f_cmd, f_data, f_nvm} <= '0;
		end else begin
			f_ov <= (f_ov && !clr_go) || ev_ov;
			f_oc <= (f_oc && !clr_go) || ev_oc;
			f_warn <= (f_warn && !clr_go) || ev_warn;
			f_uv <= (f_uv && !clr_go) || ev_uv;
			f_vinov <= (f_vinov && !clr_go) || ev_vinov;
			f_temp <= (f_temp && !clr_go) || ev_temp;
			f_data <= (f_data && !clr_go) || data_bad;
			f_cmd <= (f_cmd && !clr_go) || cmd_bad;
			f_nvm <= (f_nvm && !clr_go) || nvm_fail_i;
		end
	end

	// registered so every latched-flag bit starts at zero after reset; bits 6 and 11 follow output and pgood
	always_ff @(posedge sys_clk_i) begin
		if (rst_i) begin
			status_word <= '0;
			vout_status <= '0;
			cur_status <= '0;
			alert_o <= 1'b0;
		end else begin
			status_word <= '0;
			status_word[SW_VOUT] <= f_ov;
			status_word[SW_IOUT] <= f_oc || f_warn;
			status_word[SW_INPUT] <= f_uv || f_vinov;
			status_word[SW_PGN] <= !pgood;
			status_word[SW_OFF] <= !out_enable_o;
			status_word[SW_OV] <= f_ov;
			status_word[SW_OC] <= f_oc;
			status_word[SW_UV] <= f_uv;
			status_word[SW_TEMP] <= f_temp;
			status_word[SW_CML] <= f_cmd || f_data || f_nvm;
			vout_status <= '0;
			vout_status[SV_OV] <= f_ov;
			cur_status <= '0;
			cur_status[SI_OC] <= f_oc;
			cur_status[SI_WARN] <= f_warn;
			alert_o <= f_ov || f_oc || f_warn || f_uv || f_vinov || f_temp
				|| f_cmd || f_data || f_nvm;
		end
	end

	// start-up sequencer counting half-millisecond ticks
	logic [TW-1:0] tick_cnt;
	logic [9:0] half_ms;
	logic run, tick, trip;
	assign run = operation[OP_EN_BIT] && on_pin;
	assign trip = f_ov || f_oc;
	assign tick = (tick_cnt == TICK_LAST);

	always_ff @(posedge sys_clk_i) begin
		if (rst_i) begin
			seq <= SEQ_OFF;
			tick_cnt <= '0;
			half_ms <= '0;
		end else if (!run || trip) begin
			seq <= SEQ_OFF;
			tick_cnt <= '0;
			half_ms <= '0;
		end else begin
			tick_cnt <= tick ? '0 : tick_cnt + 1'b1;
			unique case (seq)
				SEQ_OFF: begin
					seq <= SEQ_DELAY;
					tick_cnt <= '0;
				end
				SEQ_DELAY: begin
					if (tick) begin
						half_ms <= half_ms + 1'b1;
						if (half_ms + 1'b1 >= cfg.ton_delay[9:0]) begin
							seq <= SEQ_RISE;
							half_ms <= '0;
						end
					end
				end
				SEQ_RISE: begin
					if (tick) begin
						half_ms <= half_ms + 1'b1;
						if (half_ms + 1'b1 >= cfg.ton_rise[9:0]) begin
							seq <= SEQ_ON;
							half_ms <= '0;
						end
					end
				end
				SEQ_ON: half_ms <= '0;
			endcase
		end
	end

	always_ff @(posedge sys_clk_i) begin
		if (rst_i) begin
			out_enable_o <= 1'b0;
			ramp_active_o <= 1'b0;
			vout_target_o <= '0;
		end else begin
			out_enable_o <= (seq == SEQ_RISE) || (seq == SEQ_ON);
			ramp_active_o <= (seq == SEQ_RISE);
			unique case (margin_sel)
				MRG_LOW: vout_target_o <= cfg.margin_lo;
				MRG_HIGH: vout_target_o <= cfg.margin_hi;
				default: vout_target_o <= cfg.vout_set;
			endcase
		end
	end

	// telemetry with factory correction
	logic signed [17:0] vout_sum;
	logic [25:0] vin_prod;
	logic signed [14:0] vin_sum;
	logic [26:0] cur_prod;
	logic signed [16:0] cur_sum;
	logic [9:0] vin_m, cur_m;

	always_comb begin
		vout_sum = $signed({2'b00, vout_adc_i})
			+ $signed({{2{cal_i.vout_trim[15]}}, cal_i.vout_trim});
		vin_prod = vin_adc_i * cal_i.vin_scale;
		vin_sum = $signed({2'b00, vin_prod[25:GAIN_SHIFT]})
			+ $signed({{4{cal_i.vin_trim[10]}}, cal_i.vin_trim[10:0]});
		cur_prod = iout_adc_i * cal_i.cur_scale;
		cur_sum = $signed({3'b000, cur_prod[26:GAIN_SHIFT]})
			+ $signed({{6{cal_i.cur_trim[10]}}, cal_i.cur_trim[10:0]})
			+ $signed({{6{iout_temp_adj_i[10]}}, iout_temp_adj_i});
		vin_m = vin_sum[14] ? '0 : (|vin_sum[13:10] ? MANT_MAX : vin_sum[9:0]);
		cur_m = cur_sum[16] ? '0 : (|cur_sum[15:10] ? MANT_MAX : cur_sum[9:0]);
	end

	always_ff @(posedge sys_clk_i) begin
		if (rst_i) begin
			rd_vout <= '0;
			rd_vin <= '0;
			rd_cur <= '0;
			rd_temp <= '0;
		end else begin
			rd_vout <= vout_sum[17] ? '0 : (vout_sum[16] ? '1 : vout_sum[15:0]);
			// exponent -3, top mantissa bit zero
			rd_vin <= {EXP_M3, 1'b0, vin_m};
			if (iout_sinking_i || cur_m < IOUT_BLANK) begin
				rd_cur <= {EXP_M4, 11'h000};
			end else begin
				rd_cur <= {EXP_M4, 1'b0, cur_m};
			end
			rd_temp <= {EXP_M2, temp_adc_i};
		end
	end
endmodule : pcs_top

// ### tb/pcs_props.sv
`timescale 1ns/1ps
module pcs_props #(
	parameter int HALF_MS = 4
) (
	input wire logic sys_clk_i,
	input wire logic rst_i,
	input wire logic link_clk_i,
	input wire logic lk_req_valid_i,
	input wire logic lk_req_ready_o,
	input wire logic lk_rsp_valid_o,
	input wire logic on_pin_i,
	input wire logic vout_ov_evt_i,
	input wire logic out_enable_o,
	input wire logic ramp_active_o,
	input wire logic alert_o,
	input wire logic nvm_store_o
);
	logic [15:0] low_cnt;
	logic [15:0] rise_cnt;
	// saturate so a long idle span cannot wrap into a short one
	always_ff @(posedge sys_clk_i) begin
		if (rst_i || out_enable_o || !on_pin_i) begin
			low_cnt <= 16'h0000;
		end else if (low_cnt != 16'hFFFF) begin
			low_cnt <= low_cnt + 16'h0001;
		end
	end
	always_ff @(posedge sys_clk_i) begin
		if (rst_i || !ramp_active_o) begin
			rise_cnt <= 16'h0000;
		end else if (rise_cnt != 16'hFFFF) begin
			rise_cnt <= rise_cnt + 16'h0001;
		end
	end
	sequence s_accept;
		lk_req_valid_i && lk_req_ready_o;
	endsequence
	sequence s_ov_held;
		vout_ov_evt_i [*3];
	endsequence
	a_answer_time: assert property (@(posedge link_clk_i) disable iff (rst_i)
		s_accept |-> ##[3:12] lk_rsp_valid_o) else $error("answer late");
	a_no_early: assert property (@(posedge link_clk_i) disable iff (rst_i)
		s_accept |=> !lk_rsp_valid_o [*2]) else $error("answer early");
	a_ready_low: assert property (@(posedge link_clk_i) disable iff (rst_i)
		s_accept |=> !lk_req_ready_o until lk_rsp_valid_o)
		else $error("ready back before answer");
	a_rsp_pulse: assert property (@(posedge link_clk_i) disable iff (rst_i)
		lk_rsp_valid_o |-> lk_req_ready_o ##1 !lk_rsp_valid_o)
		else $error("answer pulse wrong");
	a_ov_alert: assert property (@(posedge sys_clk_i) disable iff (rst_i)
		s_ov_held |-> ##[0:2] alert_o) else $error("alert missing");
	a_ov_shutdown: assert property (@(posedge sys_clk_i) disable iff (rst_i)
		s_ov_held |-> ##[0:4] !out_enable_o) else $error("fault ignored");
	a_pin_off: assert property (@(posedge sys_clk_i) disable iff (rst_i)
		!on_pin_i [*6] |-> !out_enable_o) else $error("output on, pin off");
	a_ramp_in_on: assert property (@(posedge sys_clk_i) disable iff (rst_i)
		ramp_active_o |-> out_enable_o) else $error("ramp without enable");
	a_delay_span: assert property (@(posedge sys_clk_i) disable iff (rst_i)
		$rose(out_enable_o) |-> low_cnt >= 20 * HALF_MS - 2)
		else $error("turn-on delay short");
	a_rise_span: assert property (@(posedge sys_clk_i) disable iff (rst_i)
		$fell(ramp_active_o) && out_enable_o |-> rise_cnt >= 30 * HALF_MS - 2)
		else $error("rise time short");
	a_store_pulse: assert property (@(posedge sys_clk_i) disable iff (rst_i)
		nvm_store_o |=> !nvm_store_o) else $error("store pulse long");
endmodule : pcs_props
bind pcs_top pcs_props #(.HALF_MS(HALF_MS)) u_props (
	.sys_clk_i(sys_clk_i), .rst_i(rst_i), .link_clk_i(link_clk_i),
	.lk_req_valid_i(lk_req_valid_i), .lk_req_ready_o(lk_req_ready_o),
	.lk_rsp_valid_o(lk_rsp_valid_o), .on_pin_i(on_pin_i),
	.vout_ov_evt_i(vout_ov_evt_i), .out_enable_o(out_enable_o),
	.ramp_active_o(ramp_active_o), .alert_o(alert_o),
	.nvm_store_o(nvm_store_o));

// ### tb/pcs_host.sv
`timescale 1ns/1ps
module pcs_host (
	input wire logic link_clk_i,
	input wire logic go_i,
	input wire logic [3:0] gap_i,
	input wire pcs_pkg::pcs_req_t req_i,
	input wire logic lk_req_ready_i,
	input wire logic lk_rsp_valid_i,
	input wire pcs_pkg::pcs_rsp_t lk_rsp_i,
	output logic lk_req_valid_o,
	output pcs_pkg::pcs_req_t lk_req_o,
	output pcs_pkg::pcs_rsp_t rsp_o,
	output logic done_o
);
	import pcs_pkg::*;
	initial begin
		lk_req_valid_o = 1'b0;
		lk_req_o = '0;
		rsp_o = '0;
		done_o = 1'b0;
		forever begin
			@(posedge link_clk_i);
			if (go_i != done_o) begin
				// a slow host idles a few link cycles first
				repeat (gap_i) @(posedge link_clk_i);
				lk_req_o <= req_i;
				lk_req_valid_o <= 1'b1;
				do @(posedge link_clk_i); while (lk_req_ready_i !== 1'b1);
				lk_req_valid_o <= 1'b0;
				// released lines show inverted data, never the old word
				lk_req_o <= ~req_i;
				do @(posedge link_clk_i); while (lk_rsp_valid_i !== 1'b1);
				rsp_o <= lk_rsp_i;
				done_o <= ~done_o;
			end
		end
	end
endmodule : pcs_host

// ### tb/tb_top.sv
`timescale 1ns/1ps
module tb_top;
	import pcs_pkg::*;
	localparam int HM = 4;
	logic sys_clk_i, link_clk_i, rst_i, go, done, valid, ready, rspv;
	logic on_pin, out_en, ramp, alert, store, sink;
	logic [3:0] gap;
	logic [7:0] ev;
	logic [15:0] vout_adc, target;
	logic [9:0] vin_adc;
	logic [10:0] iout_adc, iout_adj, temp_adc;
	pcs_req_t req, lreq;
	pcs_rsp_t lrsp, hrsp;
	pcs_cal_t cal;
	pcs_image_t image, img;
	int n_fail = 0, samples_checked = 0, n;
	logic [7:0] ops [4] = '{8'hA8, 8'h98, 8'hB8, 8'h88};
	logic [15:0] tgt [4] = '{16'hC99A, 16'hB666, 16'hB666, 16'hD333};
	logic [111:0] img_exp = 112'hE970E960F814F81ED333C99AB666;
	pcs_top #(.HALF_MS(HM)) dut_u (
		.sys_clk_i(sys_clk_i), .rst_i(rst_i), .link_clk_i(link_clk_i),
		.lk_req_valid_i(valid), .lk_req_i(lreq), .lk_rsp_o(lrsp),
		.lk_req_ready_o(ready), .lk_rsp_valid_o(rspv), .on_pin_i(on_pin),
		.pgood_i(~ev[7]), .vout_ov_evt_i(ev[0]), .iout_oc_evt_i(ev[1]),
		.iout_warn_evt_i(ev[2]), .vin_uv_evt_i(ev[3]),
		.vin_ov_evt_i(ev[4]), .temp_evt_i(ev[5]), .nvm_fail_i(ev[6]),
		.cal_i(cal), .vout_adc_i(vout_adc), .vin_adc_i(vin_adc),
		.iout_adc_i(iout_adc), .iout_temp_adj_i(iout_adj),
		.iout_sinking_i(sink), .temp_adc_i(temp_adc),
		.vout_target_o(target), .out_enable_o(out_en), .ramp_active_o(ramp),
		.alert_o(alert), .nvm_store_o(store), .nvm_image_o(image));
	pcs_host u_host (.link_clk_i(link_clk_i), .go_i(go), .gap_i(gap),
		.req_i(req), .lk_req_ready_i(ready), .lk_rsp_valid_i(rspv),
		.lk_rsp_i(lrsp), .lk_req_valid_o(valid), .lk_req_o(lreq),
		.rsp_o(hrsp), .done_o(done));
	initial begin
		sys_clk_i = 1'b0;
		forever #10 sys_clk_i = ~sys_clk_i;
	end
	initial begin
		link_clk_i = 1'b0;
		#7;
		forever #80 link_clk_i = ~link_clk_i;
	end
	always @(posedge sys_clk_i) begin
		if (store === 1'b1) img <= image;
	end
	task automatic chk_val(input string nm, input logic [15:0] e,
		input logic [15:0] g);
		samples_checked++;
		if (g !== e) begin
			n_fail++;
			$display("mismatch %s expected %h seen %h", nm, e, g);
		end
	endtask : chk_val
	task automatic acc(input logic w, input logic [7:0] c,
		input logic [15:0] d, input logic k, input logic [15:0] e);
		@(negedge sys_clk_i);
		req = {w, c, d};
		go = ~go;
		for (n = 0; n < 2000 && done !== go; n++) @(negedge sys_clk_i);
		chk_val("answer seen", {15'h0000, go}, {15'h0000, done});
		chk_val("answer ok", {15'h0000, k}, {15'h0000, hrsp.ok});
		chk_val("answer data", e, hrsp.data);
	endtask : acc
	task automatic wr(input logic [7:0] c, input logic [15:0] d, input logic k);
		acc(1'b1, c, d, k, 16'h0000);
	endtask : wr
	task automatic rd(input logic [7:0] c, input logic [15:0] e);
		acc(1'b0, c, 16'h0000, 1'b1, e);
	endtask : rd
	task automatic ev_test(input logic [7:0] e, input logic [15:0] w,
		input logic [15:0] sv, input logic [15:0] si);
		@(negedge sys_clk_i);
		ev = e;
		repeat (4) @(negedge sys_clk_i);
		ev = e & 8'h80;
		rd(CMD_STATUS_WORD, w);
		rd(CMD_OUTPUT_VOLTAGE_STATUS, sv);
		rd(CMD_OUTPUT_CURRENT_STATUS, si);
		chk_val("alert", 16'h0001, {15'h0000, alert});
	endtask : ev_test
	task automatic clr();
		@(negedge sys_clk_i);
		ev = 8'h00;
		wr(CMD_CLEAR_FAULTS, 16'h0000, 1'b1);
		rd(CMD_STATUS_WORD, 16'h0040);
		chk_val("alert", 16'h0000, {15'h0000, alert});
	endtask : clr
	task automatic stop_test();
		$display("checks %0d mismatches %0d", samples_checked, n_fail);
		if (n_fail == 0 && samples_checked > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask : stop_test
	initial begin
		#200000;
		n_fail++;
		stop_test();
	end
	initial begin
		rst_i = 1'b1;
		{go, on_pin, sink, gap, ev} = '0;
		req = '0;
		cal = '{16'hFFFE, 16'h0008, 16'h2000, 16'h0000, 16'h2000};
		{vout_adc, vin_adc} = {16'h1000, 10'h12C};
		{iout_adc, iout_adj, temp_adc} = {11'h064, 11'h002, 11'h7F0};
		// reset spans several link edges so the link side sees it
		repeat (4) @(posedge link_clk_i);
		@(negedge sys_clk_i);
		rst_i = 1'b0;
		repeat (4) @(posedge link_clk_i);
		rd(CMD_STATUS_WORD, 16'h0040);
		rd(CMD_OUTPUT_VOLTAGE_STATUS, 16'h0000);
		rd(CMD_OUTPUT_CURRENT_STATUS, 16'h0000);
		rd(CMD_VOUT_MODE, 16'h0014);
		rd(CMD_VIN_ON, 16'hE910);
		$display("test defaults done");
		wr(CMD_VIN_ON, 16'hE970, 1'b1);
		wr(CMD_VIN_ON, 16'hE971, 1'b0);
		wr(CMD_VIN_ON, 16'hF170, 1'b0);
		wr(CMD_VIN_OFF, 16'hE960, 1'b1);
		wr(CMD_VIN_OFF, 16'hE961, 1'b0);
		wr(CMD_VIN_OFF, 16'hE8FF, 1'b0);
		wr(CMD_TON_DELAY, 16'hF813, 1'b0);
		wr(CMD_TON_DELAY, 16'hFBE8, 1'b1);
		wr(CMD_TON_DELAY, 16'hFBE9, 1'b0);
		wr(CMD_TON_DELAY, 16'hF814, 1'b1);
		wr(CMD_TON_RISE, 16'hF81D, 1'b0);
		wr(CMD_TON_RISE, 16'hF81E, 1'b1);
		wr(CMD_VOUT_SET, 16'h8199, 1'b0);
		wr(CMD_VOUT_SET, 16'h819A, 1'b1);
		wr(CMD_VOUT_SET, 16'hD334, 1'b0);
		wr(CMD_VOUT_SET, 16'hD333, 1'b1);
		wr(CMD_MARGIN_LO, 16'hC99A, 1'b0);
		wr(CMD_MARGIN_HI, 16'hB666, 1'b0);
		wr(CMD_STATUS_WORD, 16'h0000, 1'b0);
		acc(1'b0, CMD_CLEAR_FAULTS, 16'h0000, 1'b0, 16'h0000);
		acc(1'b0, 8'hEE, 16'h0000, 1'b0, 16'h0000);
		rd(CMD_VIN_OFF, 16'hE960);
		rd(CMD_MARGIN_LO, 16'hB666);
		gap = 4'h3;
		for (int i = 0; i < 4; i++) begin
			wr(CMD_OPERATION, {8'h00, ops[i]}, ops[i] != 8'hB8);
			repeat (8) @(negedge sys_clk_i);
			chk_val("target", tgt[i], target);
		end
		gap = 4'h0;
		rd(CMD_OPERATION, 16'h0088);
		rd(CMD_STATUS_WORD, 16'h0042);
		clr();
		$display("test settings done");
		rd(CMD_READ_VOUT, 16'h0FFE);
		rd(CMD_VOUT_TRIM, 16'hFFFE);
		rd(CMD_READ_VIN, 16'hE934);
		rd(CMD_VIN_SCALE, 16'h2000);
		rd(CMD_VIN_TRIM, 16'h0008);
		rd(CMD_CUR_TRIM, 16'h0000);
		rd(CMD_CUR_SCALE, 16'h2000);
		rd(CMD_READ_IOUT, 16'hE066);
		rd(CMD_READ_TEMP, 16'hF7F0);
		@(negedge sys_clk_i);
		iout_adc = 11'h018;
		rd(CMD_READ_IOUT, 16'hE000);
		@(negedge sys_clk_i);
		{iout_adc, sink} = {11'h064, 1'b1};
		rd(CMD_READ_IOUT, 16'hE000);
		wr(CMD_STORE_ALL, 16'h0000, 1'b1);
		for (n = 0; n < 7; n++) begin
			chk_val("image", img_exp[n*16+:16], img[n*16+:16]);
		end
		$display("test readback done");
		@(negedge sys_clk_i);
		on_pin = 1'b1;
		for (n = 0; n < 400 && out_en !== 1'b1; n++) @(negedge sys_clk_i);
		chk_val("ramp", 16'h0001, {15'h0000, ramp});
		for (n = 0; n < 400 && ramp !== 1'b0; n++) @(negedge sys_clk_i);
		chk_val("enable", 16'h0001, {15'h0000, out_en});
		ev_test(8'h05, 16'hC060, 16'h0080, 16'h0020);
		chk_val("enable", 16'h0000, {15'h0000, out_en});
		wr(CMD_OPERATION, 16'h0008, 1'b1);
		clr();
		repeat (200) @(negedge sys_clk_i);
		chk_val("enable", 16'h0000, {15'h0000, out_en});
		ev_test(8'hFA, 16'h685E, 16'h0000, 16'h0080);
		clr();
		$display("test status done");
		stop_test();
	end
endmodule : tb_top
